// ---- hw/mnx_defines.svh ----
// Offsets, field positions, opcodes and reset values of the execution slice
`ifndef MNX_DEFINES_SVH
`define MNX_DEFINES_SVH

`define OFS_INSTR 8'h00
`define OFS_WREG 8'h04
`define OFS_BANK_SEL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_PROD 8'h10
`define OFS_CTRL 8'h14
`define OFS_INDEX_BASE 8'h18
`define OFS_MEM_ADDR 8'h1c
`define OFS_MEM_DATA 8'h20

`define ST_N 4
`define ST_RANGE 3
`define ST_Z 2
`define ST_NIBBLE 1
`define ST_C 0
`define CTRL_EXT_MODE 0

`define OPC_MULL 8'h0d
`define OPC_MULF 7'h01
`define OPC_NEG 7'h36
`define OPC_NOP_HI 4'hf
`define ACC_SPLIT 8'h5f
`define ACC_HIGH_BANK 4'hf

`define RST_BYTE 8'h00
`define RST_STATUS 5'h00
`define RST_ADDR 12'h000

`endif

// ---- hw/mnx_pkg.sv ----
// Types shared by the execution slice
package mnx_pkg;
    typedef enum logic [2:0] {S_IDLE, S_Q1, S_Q2, S_Q3, S_Q4} phase_t;
    typedef enum logic [1:0] {OP_NOP, OP_MULL, OP_MULF, OP_NEG} op_t;
endpackage

// ---- hw/file_mem.sv ----
// Byte-wide data memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module file_mem
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Port
    input wire logic we,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:4095];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= mem[addr];
        end
    end
endmodule // file_mem
`default_nettype wire

// ---- hw/mul_neg_exec.sv ----
// Multiply, negate and no-operation execution slice with Avalon-MM registers
//
// Functional notes
// - Literal multiply: unsigned W times literal into product.
// - Register multiply: W times file, sources unchanged.
// - Multiplies leave all status flags unchanged.
// - Access bit selects access bank or bank register.
// - Access bank, extended set, f<=95: indexed.
// - Negate writes two's complement back to file.
// - Negate updates negative, range, carry, nibble, zero.
// - Negate decoded from 0110110, access bit, address.
// - One word, one instruction cycle each.
`include "mnx_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module mul_neg_exec
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Status
    output logic EXEC_BUSY
);
    mnx_pkg::phase_t phase, next_phase;
    mnx_pkg::op_t op, next_op;
    logic [15:0] instr, next_instr;
    logic [7:0] wreg, next_wreg;
    logic [3:0] bank_select_register, next_bank_select_register;
    logic [4:0] status, next_status;
    logic [7:0] product_high_byte, next_product_high_byte;
    logic [7:0] product_low_byte, next_product_low_byte;
    logic ext_mode, next_ext_mode;
    logic [11:0] index_base, next_index_base;
    logic [11:0] mem_ptr, next_mem_ptr;
    logic [11:0] exec_addr, next_exec_addr;
    logic [7:0] operand, next_operand;
    logic rd_ready, next_rd_ready;
    logic mem_we;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [7:0] neg_res;
    logic [31:0] bus_wmask;
    logic busy;

    function automatic mnx_pkg::op_t decode(input logic [15:0] iw);
        if (iw[15:8] == `OPC_MULL)
            decode = mnx_pkg::OP_MULL;
        else if (iw[15:9] == `OPC_MULF)
            decode = mnx_pkg::OP_MULF;
        else if (iw[15:9] == `OPC_NEG)
            decode = mnx_pkg::OP_NEG;
        else
            decode = mnx_pkg::OP_NOP;
    endfunction

    // Unlisted opcodes belong to other slices and are treated as no-operation here
    function automatic logic [11:0] operand_addr(input logic acc, input logic [7:0] f, input logic [3:0] bank,
        input logic ext, input logic [11:0] base);
        if (acc)
            operand_addr = {bank, f};
        else if (ext && f <= `ACC_SPLIT)
            operand_addr = base + {4'h0, f};
        else if (f <= `ACC_SPLIT)
            operand_addr = {4'h0, f};
        else
            operand_addr = {`ACC_HIGH_BANK, f};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    assign busy = phase != mnx_pkg::S_IDLE;
    assign EXEC_BUSY = busy;
    assign bus_wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}},
        {8{AVS_BYTEENABLE[0]}}};
    assign neg_res = ~operand + 8'h01;

    // Stalling the whole bus while busy keeps the single memory port free for the core
    assign AVS_WAITREQUEST = busy || (AVS_READ && AVS_ADDRESS == `OFS_MEM_DATA && !rd_ready);

    always_comb
    begin
        mem_we = 1'b0;
        mem_wdata = AVS_WRITEDATA[7:0];
        mem_addr = mem_ptr;
        if (busy)
        begin
            mem_addr = exec_addr;
            mem_wdata = neg_res;
            mem_we = phase == mnx_pkg::S_Q4 && op == mnx_pkg::OP_NEG;
        end
        else if (AVS_WRITE && AVS_ADDRESS == `OFS_MEM_DATA && AVS_BYTEENABLE[0])
        begin
            mem_we = 1'b1;
        end
    end

    always_comb
    begin
        case (AVS_ADDRESS)
            `OFS_INSTR: AVS_READDATA = {16'h0000, instr};
            `OFS_WREG: AVS_READDATA = {24'h000000, wreg};
            `OFS_BANK_SEL: AVS_READDATA = {28'h0000000, bank_select_register};
            `OFS_STATUS: AVS_READDATA = {27'h0000000, status};
            `OFS_PROD: AVS_READDATA = {16'h0000, product_high_byte, product_low_byte};
            `OFS_CTRL: AVS_READDATA = {31'h00000000, ext_mode};
            `OFS_INDEX_BASE: AVS_READDATA = {20'h00000, index_base};
            `OFS_MEM_ADDR: AVS_READDATA = {20'h00000, mem_ptr};
            `OFS_MEM_DATA: AVS_READDATA = {24'h000000, mem_rdata};
            default: AVS_READDATA = 32'h00000000;
        endcase
    end

    always_comb
    begin
        logic [15:0] prod;
        logic [31:0] wv;
        prod = 16'h0000;
        wv = 32'h00000000;
        next_phase = phase;
        next_op = op;
        next_instr = instr;
        next_wreg = wreg;
        next_bank_select_register = bank_select_register;
        next_status = status;
        next_product_high_byte = product_high_byte;
        next_product_low_byte = product_low_byte;
        next_ext_mode = ext_mode;
        next_index_base = index_base;
        next_mem_ptr = mem_ptr;
        next_exec_addr = exec_addr;
        next_operand = operand;
        next_rd_ready = 1'b0;
        if (AVS_READ && AVS_ADDRESS == `OFS_MEM_DATA && !busy && !rd_ready)
        begin
            next_rd_ready = 1'b1;
        end
        if (AVS_WRITE && !busy)
        begin
            case (AVS_ADDRESS)
                `OFS_INSTR:
                begin
                    wv = merge({16'h0000, instr}, AVS_WRITEDATA, bus_wmask);
                    next_instr = wv[15:0];
                    next_phase = mnx_pkg::S_Q1;
                end
                `OFS_WREG:
                begin
                    wv = merge({24'h000000, wreg}, AVS_WRITEDATA, bus_wmask);
                    next_wreg = wv[7:0];
                end
                `OFS_BANK_SEL:
                begin
                    wv = merge({28'h0000000, bank_select_register}, AVS_WRITEDATA, bus_wmask);
                    next_bank_select_register = wv[3:0];
                end
                `OFS_STATUS:
                begin
                    wv = merge({27'h0000000, status}, AVS_WRITEDATA, bus_wmask);
                    next_status = wv[4:0];
                end
                `OFS_CTRL:
                begin
                    wv = merge({31'h00000000, ext_mode}, AVS_WRITEDATA, bus_wmask);
                    next_ext_mode = wv[`CTRL_EXT_MODE];
                end
                `OFS_INDEX_BASE:
                begin
                    wv = merge({20'h00000, index_base}, AVS_WRITEDATA, bus_wmask);
                    next_index_base = wv[11:0];
                end
                `OFS_MEM_ADDR:
                begin
                    wv = merge({20'h00000, mem_ptr}, AVS_WRITEDATA, bus_wmask);
                    next_mem_ptr = wv[11:0];
                end
                default:
                begin
                    wv = 32'h00000000;
                end
            endcase
        end
        case (phase)
            mnx_pkg::S_IDLE:
            begin
            end
            mnx_pkg::S_Q1:
            begin
                next_op = decode(instr);
                next_exec_addr = operand_addr(instr[8], instr[7:0], bank_select_register, ext_mode, index_base);
                next_phase = mnx_pkg::S_Q2;
            end
            mnx_pkg::S_Q2:
            begin
                next_phase = mnx_pkg::S_Q3;
            end
            mnx_pkg::S_Q3:
            begin
                if (op == mnx_pkg::OP_MULL)
                    next_operand = instr[7:0];
                else if (op != mnx_pkg::OP_NOP)
                    next_operand = mem_rdata;
                next_phase = mnx_pkg::S_Q4;
            end
            mnx_pkg::S_Q4:
            begin
                next_phase = mnx_pkg::S_IDLE;
                if (op == mnx_pkg::OP_MULL || op == mnx_pkg::OP_MULF)
                begin
                    prod = {8'h00, wreg} * {8'h00, operand};
                    next_product_high_byte = prod[15:8];
                    next_product_low_byte = prod[7:0];
                end
                else if (op == mnx_pkg::OP_NEG)
                begin
                    next_status[`ST_N] = neg_res[7];
                    next_status[`ST_Z] = neg_res == 8'h00;
                    next_status[`ST_C] = operand == 8'h00;
                    next_status[`ST_NIBBLE] = operand[3:0] == 4'h0;
                    next_status[`ST_RANGE] = operand == 8'h80;
                end
            end
            default:
            begin
                next_phase = mnx_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            phase <= mnx_pkg::S_IDLE;
            op <= mnx_pkg::OP_NOP;
            instr <= 16'h0000;
            wreg <= `RST_BYTE;
            bank_select_register <= 4'h0;
            status <= `RST_STATUS;
            product_high_byte <= `RST_BYTE;
            product_low_byte <= `RST_BYTE;
            ext_mode <= 1'b0;
            index_base <= `RST_ADDR;
            mem_ptr <= `RST_ADDR;
            exec_addr <= `RST_ADDR;
            operand <= `RST_BYTE;
            rd_ready <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            op <= next_op;
            instr <= next_instr;
            wreg <= next_wreg;
            bank_select_register <= next_bank_select_register;
            status <= next_status;
            product_high_byte <= next_product_high_byte;
            product_low_byte <= next_product_low_byte;
            ext_mode <= next_ext_mode;
            index_base <= next_index_base;
            mem_ptr <= next_mem_ptr;
            exec_addr <= next_exec_addr;
            operand <= next_operand;
            rd_ready <= next_rd_ready;
        end
    end

    file_mem u_mem
    (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    a_mull_product: assert property ((phase == mnx_pkg::S_Q4 && op == mnx_pkg::OP_MULL) |=>
        {product_high_byte, product_low_byte} == {8'h00, wreg} * {8'h00, $past(instr[7:0])})
        else $error("literal product wrong");
    a_mulf_sources: assert property ((busy && op == mnx_pkg::OP_MULF) |->
        !mem_we ##1 wreg == $past(wreg))
        else $error("multiply source changed");
    a_mul_flags_kept: assert property ((phase == mnx_pkg::S_Q4 && (op == mnx_pkg::OP_MULL ||
        op == mnx_pkg::OP_MULF)) |=> $stable(status))
        else $error("multiply touched flags");
    a_bank_addr: assert property ((phase == mnx_pkg::S_Q2 && instr[8]) |->
        mem_addr == {bank_select_register, instr[7:0]})
        else $error("banked address wrong");
    a_indexed_addr: assert property ((phase == mnx_pkg::S_Q2 && !instr[8] && ext_mode &&
        instr[7:0] <= 8'h5f) |-> mem_addr == index_base + {4'h0, instr[7:0]})
        else $error("indexed address wrong");
    a_negate_write: assert property ((phase == mnx_pkg::S_Q4 && op == mnx_pkg::OP_NEG) |->
        mem_we && mem_wdata == 8'h00 - operand && mem_addr == exec_addr)
        else $error("negate write wrong");
    a_negate_zero: assert property ((phase == mnx_pkg::S_Q4 && op == mnx_pkg::OP_NEG &&
        operand == 8'h00) |=> status == 5'h07)
        else $error("negate of zero flags wrong");
    a_negate_decode: assert property ((phase == mnx_pkg::S_Q1 && instr[15:9] == 7'h36) |=>
        op == mnx_pkg::OP_NEG)
        else $error("negate not decoded");
    a_cycle_phases: assert property ((phase == mnx_pkg::S_Q1) |=> phase == mnx_pkg::S_Q2 ##1
        phase == mnx_pkg::S_Q3 ##1 phase == mnx_pkg::S_Q4 ##1 phase == mnx_pkg::S_IDLE)
        else $error("instruction cycle length wrong");
    a_nop_quiet: assert property ((phase == mnx_pkg::S_Q4 && op == mnx_pkg::OP_NOP) |-> !mem_we ##1
        ($stable(status) && $stable(product_low_byte) && $stable(product_high_byte)))
        else $error("no-operation changed state");
endmodule // mul_neg_exec
`default_nettype wire

// ---- verification/tb_mul_neg_exec.sv ----
// Self-checking testbench for the multiply, negate and no-operation execution slice
`include "mnx_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_mul_neg_exec;
    logic ref_clk;
    logic sys_rst;
    logic rd;
    logic wr;
    logic wait_req;
    logic busy;
    logic [7:0] adr;
    logic [31:0] wd;
    logic [31:0] rdat;
    logic [3:0] be;
    int miscompares;
    int cmp_count;

    mul_neg_exec u_dut
    (
        .REF_CLK(ref_clk),
        .SYS_RST(sys_rst),
        .AVS_ADDRESS(adr),
        .AVS_READ(rd),
        .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd),
        .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_req),
        .EXEC_BUSY(busy)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Waitrequest and read data are taken at the rising edge, before that edge's own updates land
    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        adr <= a;
        wd <= d;
        rd <= !is_wr;
        wr <= is_wr;
        @(posedge ref_clk);
        while (wait_req !== 1'b0)
        begin
            @(posedge ref_clk);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic bwr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic poke(input logic [11:0] a, input logic [7:0] v);
        bwr(`OFS_MEM_ADDR, {20'h0, a});
        bwr(`OFS_MEM_DATA, {24'h0, v});
    endtask

    task automatic peek(input logic [11:0] a, input logic [7:0] e);
        bwr(`OFS_MEM_ADDR, {20'h0, a});
        rchk("memory", `OFS_MEM_DATA, {24'h0, e});
    endtask

    // Busy is counted from the edge that accepts the instruction write
    task automatic exec(input logic [15:0] w);
        int n;
        n = 0;
        bwr(`OFS_INSTR, {16'h0, w});
        repeat (8)
        begin
            @(negedge ref_clk);
            if (busy === 1'b1)
                n++;
        end
        chk("busy cycles", 32'd4, n);
    endtask

    task automatic t_mull;
        bwr(`OFS_WREG, 32'he2);
        bwr(`OFS_STATUS, 32'h15);
        exec(16'h0dc4);
        rchk("product", `OFS_PROD, 32'had08);
        rchk("w", `OFS_WREG, 32'he2);
        rchk("status", `OFS_STATUS, 32'h15);
        bwr(`OFS_STATUS, 32'h00);
        exec(16'h0d00);
        rchk("zero product", `OFS_PROD, 32'h0);
        rchk("status zero", `OFS_STATUS, 32'h0);
        bwr(8'hfc, 32'h5a);
        rchk("unmapped", 8'hfc, 32'h0);
        $display("TEST literal multiply done");
    endtask

    task automatic t_mulf;
        bwr(`OFS_BANK_SEL, 32'h2);
        poke(12'h240, 8'hb5);
        bwr(`OFS_WREG, 32'hc4);
        exec(16'h0340);
        rchk("product", `OFS_PROD, 32'h8a94);
        rchk("w", `OFS_WREG, 32'hc4);
        peek(12'h240, 8'hb5);
        $display("TEST register multiply done");
    endtask

    // Operand, result and flags for ordinary, most negative and zero operands
    task automatic t_neg;
        logic [7:0] src [3] = '{8'h3a, 8'h80, 8'h00};
        logic [7:0] res [3] = '{8'hc6, 8'h80, 8'h00};
        logic [4:0] st [3] = '{5'h10, 5'h1a, 5'h07};
        for (int i = 0; i < 3; i++)
        begin
            poke(12'hf60, src[i]);
            exec(16'h6c60);
            peek(12'hf60, res[i]);
            rchk("status", `OFS_STATUS, {27'h0, st[i]});
        end
        $display("TEST negate done");
    endtask

    task automatic t_index;
        bwr(`OFS_CTRL, 32'h1);
        bwr(`OFS_INDEX_BASE, 32'h300);
        poke(12'h310, 8'h3a);
        exec(16'h6c10);
        peek(12'h310, 8'hc6);
        bwr(`OFS_CTRL, 32'h0);
        poke(12'h010, 8'h01);
        exec(16'h6c10);
        peek(12'h010, 8'hff);
        $display("TEST indexed operand done");
    endtask

    task automatic t_nop;
        logic [15:0] w [3] = '{16'h0000, 16'hf123, 16'hffff};
        bwr(`OFS_STATUS, 32'h1f);
        bwr(`OFS_WREG, 32'h55);
        for (int i = 0; i < 3; i++)
        begin
            exec(w[i]);
            rchk("product", `OFS_PROD, 32'h8a94);
            rchk("status", `OFS_STATUS, 32'h1f);
            rchk("w", `OFS_WREG, 32'h55);
        end
        $display("TEST no operation done");
    endtask

    // A full run takes a few hundred cycles; the limit leaves a wide margin
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end

    initial
    begin
        miscompares = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        adr = 8'h00;
        wd = 32'h0;
        be = 4'hf;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_mull();
        t_neg();
        t_index();
        t_mulf();
        t_nop();
        print_verdict();
    end
endmodule // tb_mul_neg_exec
`default_nettype wire
